// ---- port_mux_defines.svh ----
// register offsets, reset values and field positions of the port function mux
// Behaviour
// RL1 - Each port 4 latch bit drives its pin low when 0 and releases it high when 1, and resets to all ones.
// RL2 - Reset clears all five function select registers so every pin starts as general purpose.
// RL3 - Every pin of ports 1, 3 and 4 picks its function on its own, with no grouping.
// RL4 - Uart and serial peripheral pins run quasi-bidirectional with a one-clock strong high pulse on each rise.
// RL5 - Timer and counter-array input pins are input-only quasi-bidirectional and carry no peripheral data.
// RL6 - An analog pin has pull-ups and both drivers off and is handed to the converter; port 1 only.
// RL7 - Two-wire pins are open drain, low driver and weak pull-ups only, never a strong high pulse; port 3 only.
// RL8 - Counter-array output pins are push-pull, both levels actively driven; port 4 only.
// RL9 - Port 3 select bit 0 means general purpose and 1 the alternate; pins 0 and 1 are uart0 receive and transmit.
// RL10 - Port 3 pins 2..7 carry irq/gate 0 and 1, counter 0 and 1, two-wire data and clock.
// RL11 - Port 1 low select bit 0 gives general purpose, 1 with high bit 0 alternate one, 1 with 1 alternate two.
// RL12 - Port 1 alternate one is timer2 count, timer2 trigger, uart1 rx, uart1 tx, spi clock, rx, tx, select.
// RL13 - Port 1 alternate two ties pin i to analog channel i.
// RL14 - Timer 2, uart1 and serial peripheral functions may sit on port 1 or port 4 independently.
// RL15 - Port 4 uses the same two-bit code: alternate one counter-array pins and clocks, alternate two as port 1.
// RL16 - With an alternate selected the pin takes peripheral data, and the pin level goes to the peripheral.
`ifndef PORT_MUX_DEFINES_SVH
`define PORT_MUX_DEFINES_SVH

`define ADDR_P1_SEL_LO   8'h8E
`define ADDR_P1_SEL_HI   8'h8F
`define ADDR_P3_SEL      8'h91
`define ADDR_P4_SEL_LO   8'h92
`define ADDR_P4_SEL_HI   8'h93
`define ADDR_P4_LATCH    8'hC0

`define SEL_RESET        8'h00
`define P4_LATCH_RESET   8'hFF
`define PIN_IDLE         24'hFF_FFFF

`define PORT1_BASE       0
`define PORT3_BASE       8
`define PORT4_BASE       16

`endif

// ---- port_mux_pkg.sv ----
// types shared by the port function mux
package port_mux_pkg;

  // driver mode of one pad, one-hot
  typedef enum logic [5:0] {
    MODE_QUASI      = 6'b00_0001,
    MODE_INPUT      = 6'b00_0010,
    MODE_OPEN_DRAIN = 6'b00_0100,
    MODE_ANALOG     = 6'b00_1000,
    MODE_PUSH_PULL  = 6'b01_0000,
    MODE_OFF        = 6'b10_0000
  } pad_mode_t;

endpackage

// ---- port_alternate_function_mux.sv ----
// per-pin function routing and pad driver control for ports 1, 3 and 4
`timescale 1ns/100ps
`include "port_mux_defines.svh"

module port_alternate_function_mux
  import port_mux_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_rmw,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  // port latches held by the core
  input  wire logic [7:0] p1_gpio_latch,
  input  wire logic [7:0] p3_gpio_latch,
  // pad levels
  input  wire logic [7:0] p1_pin_in,
  input  wire logic [7:0] p3_pin_in,
  input  wire logic [7:0] p4_pin_in,
  // pad driver controls
  output logic      [7:0] p1_low_drive,
  output logic      [7:0] p1_high_drive,
  output logic      [7:0] p1_pullup_en,
  output logic      [7:0] p1_analog_en,
  output logic      [7:0] p3_low_drive,
  output logic      [7:0] p3_high_drive,
  output logic      [7:0] p3_pullup_en,
  output logic      [7:0] p4_low_drive,
  output logic      [7:0] p4_high_drive,
  output logic      [7:0] p4_pullup_en,
  // filtered pin levels for the core
  output logic      [7:0] p1_pin_level,
  output logic      [7:0] p3_pin_level,
  // peripheral outputs towards the pins
  input  wire logic       uart0_transmit,
  input  wire logic       uart1_transmit,
  input  wire logic       serial_periph_clock,
  input  wire logic       serial_periph_transmit,
  input  wire logic       serial_periph_select_n,
  input  wire logic       twowire_data_out,
  input  wire logic       twowire_clock_out,
  input  wire logic [5:0] pca_module_pin_out,
  input  wire logic [5:0] pca_module_output_mode,
  // peripheral inputs from the pins
  output logic            uart0_receive,
  output logic            uart1_receive,
  output logic            serial_periph_receive,
  output logic            ext_irq0_timer0_gate,
  output logic            ext_irq1_timer1_gate,
  output logic            counter0_input,
  output logic            counter1_input,
  output logic            twowire_data_in,
  output logic            twowire_clock_in,
  output logic            timer2_count_input,
  output logic            timer2_trigger_input,
  output logic      [5:0] pca_module_pin_in,
  output logic      [1:0] pca_external_clock
);

  // pad mode of pin idx (0..23) for a given select code
  function automatic pad_mode_t pin_mode(input int unsigned idx, input logic alt_one,
                                         input logic alt_two, input logic pca_drive);
    pad_mode_t   m;
    int unsigned bit_n;
    m     = MODE_QUASI;
    bit_n = idx % 8;
    if (alt_one) begin
      case (idx / 8)
        0: m = (bit_n < 2) ? MODE_INPUT : MODE_QUASI;                     // [RL5] [RL4]
        1: m = (bit_n < 2) ? MODE_QUASI :
               (bit_n < 6) ? MODE_INPUT : MODE_OPEN_DRAIN;                // [RL10] [RL7]
        2: m = ((bit_n == 3) || (bit_n == 7)) ? MODE_INPUT :
               (pca_drive ? MODE_PUSH_PULL : MODE_INPUT);                 // [RL8] [RL5]
        default: m = MODE_QUASI;
      endcase
    end else if (alt_two) begin
      case (idx / 8)
        0: m = MODE_ANALOG;                                               // [RL6] [RL13]
        2: m = (bit_n < 2) ? MODE_INPUT : MODE_QUASI;                     // [RL15]
        default: m = MODE_QUASI;
      endcase
    end
    return m;
  endfunction

  // select registers and port 4 latch
  logic [7:0]  sel1_lo_q;
  logic [7:0]  sel1_hi_q;
  logic [7:0]  sel3_q;
  logic [7:0]  sel4_lo_q;
  logic [7:0]  sel4_hi_q;
  logic [7:0]  p4_latch_q;
  // pin input synchroniser and filter
  logic [23:0] sync1_q;
  logic [23:0] sync2_q;
  logic [23:0] sync3_q;
  logic [23:0] level_q;
  // per-pin routing
  logic [23:0] alt_one;
  logic [23:0] alt_two;
  logic [23:0] out_one;
  logic [23:0] out_two;
  logic [23:0] gpio_out;
  logic [23:0] pca_drive;
  logic [23:0] data_d;
  logic [23:0] data_q;
  logic [23:0] low_q;
  logic [23:0] high_q;
  logic [23:0] pull_q;
  logic [23:0] analog_q;

  // register writes; reset puts every pin back to general purpose
  always_ff @(posedge clk) begin
    if (reset) begin
      sel1_lo_q  <= `SEL_RESET;                                           // [RL2]
      sel1_hi_q  <= `SEL_RESET;
      sel3_q     <= `SEL_RESET;
      sel4_lo_q  <= `SEL_RESET;
      sel4_hi_q  <= `SEL_RESET;
      p4_latch_q <= `P4_LATCH_RESET;                                      // [RL1]
    end else if (sfr_wr) begin
      case (sfr_addr)
        `ADDR_P1_SEL_LO: sel1_lo_q  <= sfr_wdata;
        `ADDR_P1_SEL_HI: sel1_hi_q  <= sfr_wdata;
        `ADDR_P3_SEL:    sel3_q     <= sfr_wdata;
        `ADDR_P4_SEL_LO: sel4_lo_q  <= sfr_wdata;
        `ADDR_P4_SEL_HI: sel4_hi_q  <= sfr_wdata;
        `ADDR_P4_LATCH:  p4_latch_q <= sfr_wdata;                         // [RL1]
        default: ;
      endcase
    end
  end

  // register reads; latch for read-modify-write, pins otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else if (sfr_rd) begin
      sfr_hit <= 1'b1;
      case (sfr_addr)
        `ADDR_P1_SEL_LO: sfr_rdata <= sel1_lo_q;
        `ADDR_P1_SEL_HI: sfr_rdata <= sel1_hi_q;
        `ADDR_P3_SEL:    sfr_rdata <= sel3_q;
        `ADDR_P4_SEL_LO: sfr_rdata <= sel4_lo_q;
        `ADDR_P4_SEL_HI: sfr_rdata <= sel4_hi_q;
        `ADDR_P4_LATCH:  sfr_rdata <= sfr_rmw ? p4_latch_q : level_q[23:16];
        default: begin
          sfr_rdata <= 8'h00;
          sfr_hit   <= 1'b0;
        end
      endcase
    end else begin
      sfr_hit <= 1'b0;
    end
  end

  // three-stage sync; a level counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= `PIN_IDLE;
      sync2_q <= `PIN_IDLE;
      sync3_q <= `PIN_IDLE;
      level_q <= `PIN_IDLE;
    end else begin
      sync1_q <= {p4_pin_in, p3_pin_in, p1_pin_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));
    end
  end

  // decode of the select codes, one bit per pin
  assign alt_one  = {sel4_lo_q & ~sel4_hi_q, sel3_q, sel1_lo_q & ~sel1_hi_q}; // [RL11] [RL9]
  assign alt_two  = {sel4_lo_q &  sel4_hi_q, 8'h00,  sel1_lo_q &  sel1_hi_q}; // [RL11] [RL15]
  assign gpio_out = {p4_latch_q, p3_gpio_latch, p1_gpio_latch};

  // peripheral data per pin; input-only positions sit at 1 so the pad stays released
  assign out_one[7:0]   = {serial_periph_select_n, serial_periph_transmit, 1'b1,
                           serial_periph_clock, uart1_transmit, 3'b111};     // [RL12]
  assign out_one[15:8]  = {twowire_clock_out, twowire_data_out, 4'hF,
                           uart0_transmit, 1'b1};                            // [RL9] [RL10]
  assign out_one[23:16] = {1'b1, pca_module_pin_out[5:3], 1'b1,
                           pca_module_pin_out[2:0]};                         // [RL15] [RL5]
  assign out_two[7:0]   = 8'hFF;
  assign out_two[15:8]  = 8'hFF;
  assign out_two[23:16] = out_one[7:0];                                      // [RL15]
  assign pca_drive      = {1'b0, pca_module_output_mode[5:3], 1'b0,
                           pca_module_output_mode[2:0], 16'h0000};

  // each pin decides its own mode and drivers
  for (genvar i = 0; i < 24; i++) begin : g_pin                           // [RL3]
    pad_mode_t mode_d;

    assign mode_d    = pin_mode(i, alt_one[i], alt_two[i], pca_drive[i]);
    assign data_d[i] = alt_one[i] ? out_one[i] :
                       alt_two[i] ? out_two[i] : gpio_out[i];             // [RL16]

    // registered pad controls; the strong high pulse lasts one clock on a rise
    always_ff @(posedge clk) begin
      if (reset) begin
        data_q[i]   <= 1'b1;
        low_q[i]    <= 1'b0;
        high_q[i]   <= 1'b0;
        pull_q[i]   <= 1'b1;
        analog_q[i] <= 1'b0;
      end else begin
        data_q[i]   <= data_d[i];
        analog_q[i] <= 1'b0;
        case (mode_d)
          MODE_QUASI: begin
            low_q[i]  <= ~data_d[i];                                      // [RL1]
            high_q[i] <= data_d[i] & ~data_q[i];                          // [RL4]
            pull_q[i] <= data_d[i];
          end
          MODE_INPUT: begin
            low_q[i]  <= 1'b0;                                            // [RL5]
            high_q[i] <= 1'b0;
            pull_q[i] <= 1'b1;
          end
          MODE_OPEN_DRAIN: begin
            low_q[i]  <= ~data_d[i];                                      // [RL7]
            high_q[i] <= 1'b0;
            pull_q[i] <= data_d[i];
          end
          MODE_ANALOG: begin
            low_q[i]    <= 1'b0;                                          // [RL6]
            high_q[i]   <= 1'b0;
            pull_q[i]   <= 1'b0;
            analog_q[i] <= 1'b1;
          end
          MODE_PUSH_PULL: begin
            low_q[i]  <= ~data_d[i];                                      // [RL8]
            high_q[i] <= data_d[i];
            pull_q[i] <= 1'b0;
          end
          default: begin
            low_q[i]  <= 1'b0;
            high_q[i] <= 1'b0;
            pull_q[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // pad outputs per port
  assign p1_low_drive  = low_q[7:0];
  assign p1_high_drive = high_q[7:0];
  assign p1_pullup_en  = pull_q[7:0];
  assign p1_analog_en  = analog_q[7:0];                                   // [RL13]
  assign p3_low_drive  = low_q[15:8];
  assign p3_high_drive = high_q[15:8];
  assign p3_pullup_en  = pull_q[15:8];
  assign p4_low_drive  = low_q[23:16];
  assign p4_high_drive = high_q[23:16];
  assign p4_pullup_en  = pull_q[23:16];
  assign p1_pin_level  = level_q[7:0];
  assign p3_pin_level  = level_q[15:8];

  // peripheral inputs; unselected inputs idle high, port 1 wins if both ports pick one
  always_ff @(posedge clk) begin
    if (reset) begin
      uart0_receive         <= 1'b1;
      uart1_receive         <= 1'b1;
      serial_periph_receive <= 1'b1;
      ext_irq0_timer0_gate  <= 1'b1;
      ext_irq1_timer1_gate  <= 1'b1;
      counter0_input        <= 1'b1;
      counter1_input        <= 1'b1;
      twowire_data_in       <= 1'b1;
      twowire_clock_in      <= 1'b1;
      timer2_count_input    <= 1'b1;
      timer2_trigger_input  <= 1'b1;
      pca_module_pin_in     <= 6'h3F;
      pca_external_clock    <= 2'b11;
    end else begin
      uart0_receive         <= alt_one[8]  ? level_q[8]  : 1'b1;          // [RL9]
      ext_irq0_timer0_gate  <= alt_one[10] ? level_q[10] : 1'b1;          // [RL10]
      ext_irq1_timer1_gate  <= alt_one[11] ? level_q[11] : 1'b1;
      counter0_input        <= alt_one[12] ? level_q[12] : 1'b1;
      counter1_input        <= alt_one[13] ? level_q[13] : 1'b1;
      twowire_data_in       <= alt_one[14] ? level_q[14] : 1'b1;
      twowire_clock_in      <= alt_one[15] ? level_q[15] : 1'b1;
      timer2_count_input    <= alt_one[0] ? level_q[0] :
                               alt_two[16] ? level_q[16] : 1'b1;          // [RL14]
      timer2_trigger_input  <= alt_one[1] ? level_q[1] :
                               alt_two[17] ? level_q[17] : 1'b1;          // [RL14]
      uart1_receive         <= alt_one[2] ? level_q[2] :
                               alt_two[18] ? level_q[18] : 1'b1;          // [RL14]
      serial_periph_receive <= alt_one[5] ? level_q[5] :
                               alt_two[21] ? level_q[21] : 1'b1;
      pca_module_pin_in     <= ({alt_one[22:20], alt_one[18:16]} &
                                {level_q[22:20], level_q[18:16]}) |
                               ~{alt_one[22:20], alt_one[18:16]};         // [RL16]
      pca_external_clock    <= ({alt_one[23], alt_one[19]} & {level_q[23], level_q[19]}) |
                               ~{alt_one[23], alt_one[19]};
    end
  end

endmodule // port_alternate_function_mux

// ---- port_mux_partner.sv ----
// pad model: resolves each pin from the mux drivers and external devices
`timescale 1ns/100ps
module port_mux_partner (
  // clock
  input  wire logic        clk,
  // mux pad drivers, pins 0..23
  input  wire logic [23:0] low,
  input  wire logic [23:0] high,
  input  wire logic [23:0] pull,
  // external devices pulling pins low
  input  wire logic [23:0] ext_en,
  // resolved pad levels
  output logic      [23:0] pin
);
  logic [23:0] flt_q = 24'h00_0000;
  // an undriven pin toggles, so a stale level never reads as valid
  always @(posedge clk) flt_q <= ~flt_q;
  // low driver wins, then an external device, then driver or pull-ups
  assign pin = ~low & ~ext_en & (high | pull | flt_q);
endmodule // port_mux_partner

// ---- port_mux_checker.sv ----
// concurrent checks on the port mux top ports
`timescale 1ns/100ps
module port_mux_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  // pad drivers
  input wire logic [7:0] p1_low_drive,
  input wire logic [7:0] p1_high_drive,
  input wire logic [7:0] p1_pullup_en,
  input wire logic [7:0] p1_analog_en,
  input wire logic [7:0] p3_low_drive,
  input wire logic [7:0] p3_high_drive,
  input wire logic [7:0] p3_pullup_en,
  input wire logic [7:0] p4_low_drive,
  input wire logic [7:0] p4_high_drive,
  input wire logic [7:0] p4_pullup_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic mapped;
  // any other address must read as a miss
  assign mapped = sfr_addr inside {8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93, 8'hC0};
  chk_reset_idle: assert property (
    $fell(reset) |-> p4_pullup_en == 8'hFF && p4_low_drive == 8'h00 && p1_analog_en == 8'h00)
    else $error("pads not idle after reset");
  chk_hit_mapped: assert property (sfr_rd && mapped |=> sfr_hit)
    else $error("mapped read missed");
  chk_miss_unmapped: assert property (
    sfr_rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  chk_p1_one_pulse: assert property (
    p1_high_drive != 8'h00 |=> (p1_high_drive & $past(p1_high_drive)) == 8'h00)
    else $error("port 1 strong high too long");
  chk_p3_one_pulse: assert property (
    p3_high_drive != 8'h00 |=> (p3_high_drive & $past(p3_high_drive)) == 8'h00)
    else $error("port 3 strong high too long");
  chk_no_fight: assert property (((p1_low_drive & p1_high_drive) |
    (p3_low_drive & p3_high_drive) | (p4_low_drive & p4_high_drive)) == 8'h00)
    else $error("high and low drivers both on");
  chk_low_pull_apart: assert property (((p1_low_drive & p1_pullup_en) |
    (p3_low_drive & p3_pullup_en) | (p4_low_drive & p4_pullup_en)) == 8'h00)
    else $error("pull-up on while pin driven low");
  chk_analog_off: assert property (
    ((p1_low_drive | p1_high_drive | p1_pullup_en) & p1_analog_en) == 8'h00)
    else $error("analog pin still driven");
  // main scenarios reached
  cover property (sfr_rd && mapped ##1 sfr_hit);
  cover property (p1_analog_en == 8'hFF);
  cover property (p4_high_drive[1] [*2]);
endmodule // port_mux_checker
bind port_alternate_function_mux port_mux_checker i_chk (.clk, .reset, .sfr_addr, .sfr_rd,
  .sfr_rdata, .sfr_hit, .p1_low_drive, .p1_high_drive, .p1_pullup_en, .p1_analog_en,
  .p3_low_drive, .p3_high_drive, .p3_pullup_en, .p4_low_drive, .p4_high_drive, .p4_pullup_en);

// ---- tb_top.sv ----
// self-checking bench for the port function mux
`timescale 1ns/100ps
module tb_top;
  // design inputs
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, p1_gpio_latch = 8'hFF, p3_gpio_latch = 8'hFF;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
  logic        uart0_transmit = 1'b1, uart1_transmit = 1'b1, serial_periph_clock = 1'b1;
  logic        serial_periph_transmit = 1'b1, serial_periph_select_n = 1'b1;
  logic        twowire_data_out = 1'b1, twowire_clock_out = 1'b1;
  logic [5:0]  pca_module_pin_out = 6'h00, pca_module_output_mode = 6'h00;
  logic [23:0] ext_en = 24'h00_0000;
  // design outputs and pads
  logic [7:0]  sfr_rdata, p1_low_drive, p1_high_drive, p1_pullup_en, p1_analog_en, p3_low_drive;
  logic [7:0]  p3_high_drive, p3_pullup_en, p4_low_drive, p4_high_drive, p4_pullup_en;
  logic [7:0]  p1_pin_level, p3_pin_level, seen_high;
  logic        sfr_hit, uart0_receive, uart1_receive, serial_periph_receive, twowire_data_in;
  logic        ext_irq0_timer0_gate, ext_irq1_timer1_gate, counter0_input, counter1_input;
  logic        twowire_clock_in, timer2_count_input, timer2_trigger_input;
  logic [5:0]  pca_module_pin_in;
  logic [1:0]  pca_external_clock;
  logic [23:0] pin;
  logic [7:0]  sel_a [5] = '{8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93};
  int          num_errors = 0, cmp_count = 0, cycles = 0, n;

  port_alternate_function_mux i_dut (
    .clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_rdata, .sfr_hit,
    .p1_gpio_latch, .p3_gpio_latch, .p1_pin_in(pin[7:0]), .p3_pin_in(pin[15:8]),
    .p4_pin_in(pin[23:16]), .p1_low_drive, .p1_high_drive, .p1_pullup_en, .p1_analog_en,
    .p3_low_drive, .p3_high_drive, .p3_pullup_en, .p4_low_drive, .p4_high_drive,
    .p4_pullup_en, .p1_pin_level, .p3_pin_level, .uart0_transmit, .uart1_transmit,
    .serial_periph_clock, .serial_periph_transmit, .serial_periph_select_n,
    .twowire_data_out, .twowire_clock_out, .pca_module_pin_out, .pca_module_output_mode,
    .uart0_receive, .uart1_receive, .serial_periph_receive, .ext_irq0_timer0_gate,
    .ext_irq1_timer1_gate, .counter0_input, .counter1_input, .twowire_data_in,
    .twowire_clock_in, .timer2_count_input, .timer2_trigger_input, .pca_module_pin_in,
    .pca_external_clock);
  port_mux_partner i_pads (.clk, .low({p4_low_drive, p3_low_drive, p1_low_drive}),
    .high({p4_high_drive, p3_high_drive, p1_high_drive}),
    .pull({p4_pullup_en, p3_pullup_en, p1_pullup_en}), .ext_en, .pin);

  always #4 clk = ~clk;
  // hang guard, the run needs about 140 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // data and hit stand in the cycle after the read edge
  task automatic rd_reg(input logic [7:0] a, input logic m, input logic [7:0] e, input logic h);
    @(negedge clk);
    sfr_addr = a;
    sfr_rmw = m;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check(sfr_rdata, e);
    check({7'h00, sfr_hit}, {7'h00, h});
  endtask
  // pad register plus three-stage pin filter fit well inside eight cycles
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s done, mismatches %0d", s, num_errors);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    foreach (sel_a[i]) rd_reg(sel_a[i], 1'b0, 8'h00, 1'b1);
    rd_reg(8'hC0, 1'b1, 8'hFF, 1'b1);
    rd_reg(8'h90, 1'b0, 8'h00, 1'b0);
    check(p1_pin_level, 8'hFF);
    done("reset values");
    // bit 0 low, read the pin back, then release with one strong high cycle
    wr_reg(8'hC0, 8'hFE);
    settle();
    check(p4_low_drive, 8'h01);
    rd_reg(8'hC0, 1'b0, 8'hFE, 1'b1);
    wr_reg(8'hC0, 8'hFF);
    n = 0;
    while (p4_high_drive[0] !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    check(p4_high_drive, 8'h01);
    @(negedge clk);
    check(p4_high_drive, 8'h00);
    done("port 4 latch");
    // distinct pattern per select register, then a mid-run reset
    foreach (sel_a[i]) wr_reg(sel_a[i], sel_a[i] ^ 8'h5A);
    foreach (sel_a[i]) rd_reg(sel_a[i], 1'b0, sel_a[i] ^ 8'h5A, 1'b1);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    foreach (sel_a[i]) rd_reg(sel_a[i], 1'b0, 8'h00, 1'b1);
    done("select registers");
    // port 3 all alternate: uart0, irq/gate, counters, two-wire
    wr_reg(8'h91, 8'hFF);
    uart0_transmit = 1'b0;
    twowire_data_out = 1'b0;
    ext_en = 24'h00_3D00;
    settle();
    check({1'b0, uart0_receive, ext_irq0_timer0_gate, ext_irq1_timer1_gate, counter0_input,
           counter1_input, twowire_data_in, twowire_clock_in}, 8'h01);
    check(p3_low_drive, 8'h42);
    check(p3_pullup_en, 8'hBD);
    check(p3_pin_level, 8'h80);
    uart0_transmit = 1'b1;
    twowire_data_out = 1'b1;
    seen_high = 8'h00;
    repeat (4) begin
      @(negedge clk);
      seen_high = seen_high | p3_high_drive;
    end
    check(seen_high, 8'h02);
    done("port 3");
    // port 1 alternate one, then two, then back to the latch
    ext_en = 24'h00_0027;
    p1_gpio_latch = 8'h00;
    {uart1_transmit, serial_periph_clock, serial_periph_transmit, serial_periph_select_n} = 4'h0;
    wr_reg(8'h8E, 8'hFF);
    settle();
    check({4'h0, timer2_count_input, timer2_trigger_input, uart1_receive,
           serial_periph_receive}, 8'h00);
    check(p1_low_drive, 8'hD8);
    check(p1_pin_level, 8'h00);
    wr_reg(8'h8F, 8'hFF);
    settle();
    check(p1_analog_en, 8'hFF);
    check(p1_low_drive | p1_high_drive | p1_pullup_en, 8'h00);
    wr_reg(8'h8E, 8'h00);
    settle();
    check(p1_analog_en, 8'h00);
    check(p1_low_drive, 8'hFF);
    done("port 1");
    // port 4 counter-array push-pull, then split peripherals onto port 4
    pca_module_output_mode = 6'h3F;
    pca_module_pin_out = 6'h2A;
    ext_en = 24'h08_0000;
    wr_reg(8'h92, 8'hFF);
    settle();
    check(p4_high_drive, 8'h52);
    check(p4_low_drive, 8'h25);
    check(p4_pullup_en, 8'h88);
    check({6'h00, pca_external_clock}, 8'h02);
    check({2'b00, pca_module_pin_in}, 8'h2A);
    // modules as inputs: pads released, pin levels reach the counter array
    pca_module_output_mode = 6'h00;
    ext_en = 24'h41_0000;
    settle();
    check(p4_low_drive | p4_high_drive, 8'h00);
    check(p4_pullup_en, 8'hFF);
    check({2'b00, pca_module_pin_in}, 8'h1E);
    ext_en = 24'h05_0000;
    wr_reg(8'h93, 8'hFF);
    settle();
    check(p4_low_drive, 8'hD8);
    check({6'h00, uart1_receive, timer2_count_input}, 8'h00);
    done("port 4");
    report_and_stop();
  end
endmodule // tb_top
